// File: design/sbpg_pkg.sv
package sbpg_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on the avalon word bus)
   // ----------------------------------------------------------------
   localparam logic [3:0] SBPG_OFS_CLK_WIDTH  = 4'h0;   // clock select and high width
   localparam logic [3:0] SBPG_OFS_EN_CYCLE   = 4'h4;   // enable and cycle setting
   localparam logic [3:0] SBPG_OFS_STATUS     = 4'h8;   // counter and waveform state, read only
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SBPG_SEL_MSB   = 7;                   // clock select field top
   localparam int SBPG_SEL_LSB   = 6;                   // clock select field bottom
   localparam int SBPG_VAL_MSB   = 5;                   // width / cycle field top
   localparam int SBPG_EN_BIT    = 7;                   // output enable bit
   localparam int SBPG_STAT_PIN  = 8;                   // waveform level in status word
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SBPG_RST_SEL   = 2'h0;        // fastest count clock
   localparam logic [5:0] SBPG_RST_VAL   = 6'h00;       // width and cycle cleared
   localparam logic [5:0] SBPG_CNT_ZERO  = 6'h00;       // counter start value
   // ----------------------------------------------------------------
   // count clock dividers, in instruction cycles
   // ----------------------------------------------------------------
   localparam int SBPG_DIV_0 = 1;
   localparam int SBPG_DIV_1 = 2;
   localparam int SBPG_DIV_2 = 8;
   localparam int SBPG_DIV_3 = 32;
   localparam int SBPG_INST_CYC = 4;                    // system clocks per instruction cycle
endpackage : sbpg_pkg

// File: design/sbpg_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
// count clock strobes between prescaler and pulse generator
interface sbpg_tick_if;
   logic [3:0] tick;                                    // one-cycle strobes per rate
   modport source (output tick);
   modport sink   (input tick);
endinterface : sbpg_tick_if
`default_nettype wire

// File: design/sbpg_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
// shared prescaler making the four count clock strobes
module sbpg_prescaler
   import sbpg_pkg::*;
#(
   parameter int INST_CYC = SBPG_INST_CYC               // system clocks per instruction cycle
)
(
   input  wire logic      i_ref_clk,
   input  wire logic      i_rst_n,
   sbpg_tick_if.source    tick_bus
);
   // ----------------------------------------------------------------
   // instruction cycle divider
   // ----------------------------------------------------------------
   localparam int DIVS [4] = '{SBPG_DIV_0, SBPG_DIV_1, SBPG_DIV_2, SBPG_DIV_3};   // strobe rates
   // refuse an instruction cycle the eight-bit divider cannot count
   if (INST_CYC < 1 || INST_CYC > 255)
   begin : g_bad_inst
      $error("sbpg_prescaler: bad INST_CYC");
   end
   logic [7:0] inst_q;                                  // system clock count
   logic [4:0] pre_q;                                   // instruction cycle count
   logic       inst_tick;                               // one pulse per instruction cycle
   assign inst_tick = (inst_q == 8'(INST_CYC - 1));
   // divide system clock down to instruction cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         inst_q <= 8'h00;
      else if (inst_tick)
         inst_q <= 8'h00;
      else
         inst_q <= inst_q + 8'h01;
   // free running instruction cycle counter
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         pre_q <= 5'h00;
      else if (inst_tick)
         pre_q <= pre_q + 5'h01;
   // ----------------------------------------------------------------
   // strobes at 1, 2, 8 and 32 instruction cycles
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 4; k++)
   begin : g_tick
      // rate must be a power of two the five-bit count can mark
      if (DIVS[k] < 1 || DIVS[k] > 32 || (DIVS[k] & (DIVS[k] - 1)) != 0)
      begin : g_bad_div
         $error("sbpg_prescaler: divider not a power of two up to 32");
      end
      // strobe when the low count bits are all ones
      assign tick_bus.tick[k] = inst_tick && ((pre_q & 5'(DIVS[k] - 1)) == 5'(DIVS[k] - 1));
   end
endmodule : sbpg_prescaler
`default_nettype wire

// File: design/sbpg_top.sv
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sbpg_top
   import sbpg_pkg::*;
#(
   parameter int INST_CYC = SBPG_INST_CYC               // system clocks per instruction cycle
)
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_avs_address,              // byte address
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_port_data,                // general purpose port level
   output logic             o_pulse_output_pin,         // pin level
   output logic             o_pulse_output_function     // high while pin carries waveform
);
   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [1:0] count_clock_select_q;                    // count clock choice
   logic [5:0] high_width_setting_q;                    // high width compare value
   logic       pulse_output_enable_q;                   // output and count enable
   logic [5:0] cycle_setting_q;                         // cycle compare value
   logic [5:0] cnt_q;                                   // six-bit counter
   logic       wave_q;                                  // comparator output
   logic       ack;                                     // bus answer phase, waitrequest low
   logic       hit;                                     // selected count strobe
   logic       wr_en, rd_en;                            // taken accesses
   logic       lane0;                                   // low byte enabled
   sbpg_tick_if tick_bus ();                            // prescaler strobes
   // count clock strobes from the shared prescaler
   sbpg_prescaler #(.INST_CYC(INST_CYC)) u_pre (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tick_bus  (tick_bus)
   );
   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, answer on second edge
   // ----------------------------------------------------------------
   assign ack   = !o_avs_waitrequest;
   assign wr_en = i_avs_write && ack;                   // write lands on the answer edge
   assign rd_en = i_avs_read && !ack;                   // read data loaded one cycle early
   assign lane0 = i_avs_byteenable[0];
   // waitrequest high at request start, low for one cycle to finish
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_avs_waitrequest <= 1'b1;
      else
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
   // clock select and high width register
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         count_clock_select_q <= SBPG_RST_SEL;
         high_width_setting_q <= SBPG_RST_VAL;
      end
      else if (wr_en && lane0 && i_avs_address == SBPG_OFS_CLK_WIDTH)
      begin
         count_clock_select_q <= i_avs_writedata[SBPG_SEL_MSB:SBPG_SEL_LSB];
         high_width_setting_q <= i_avs_writedata[SBPG_VAL_MSB:0];
      end
   // enable and cycle register
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         pulse_output_enable_q <= 1'b0;
         cycle_setting_q       <= SBPG_RST_VAL;
      end
      else if (wr_en && lane0 && i_avs_address == SBPG_OFS_EN_CYCLE)
      begin
         pulse_output_enable_q <= i_avs_writedata[SBPG_EN_BIT];
         cycle_setting_q       <= i_avs_writedata[SBPG_VAL_MSB:0];
      end
   // read data, unmapped reads as zero
   // loaded at the request edge so it stands while waitrequest is low
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_avs_readdata <= 32'h0000_0000;
      else if (rd_en)
         unique case (i_avs_address)
            SBPG_OFS_CLK_WIDTH: o_avs_readdata <= {24'h000000, count_clock_select_q, high_width_setting_q};
            SBPG_OFS_EN_CYCLE:  o_avs_readdata <= {24'h000000, pulse_output_enable_q, 1'b0, cycle_setting_q};
            SBPG_OFS_STATUS:    o_avs_readdata <= {23'h000000, wave_q, 2'h0, cnt_q};
            default:            o_avs_readdata <= 32'h0000_0000;
         endcase
   // ----------------------------------------------------------------
   // count clock selector and counter
   // ----------------------------------------------------------------
   assign hit = tick_bus.tick[count_clock_select_q];
   // counter: cleared while disabled, wraps on cycle match
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         cnt_q <= SBPG_CNT_ZERO;
      else if (!pulse_output_enable_q)
         cnt_q <= SBPG_CNT_ZERO;
      else if (hit)
      begin
         if (cnt_q + 6'h01 == cycle_setting_q)
            cnt_q <= SBPG_CNT_ZERO;
         else
            cnt_q <= cnt_q + 6'h01;
      end
   // ----------------------------------------------------------------
   // comparator
   // ----------------------------------------------------------------
   // high from count zero until width match, then low until cycle end
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         wave_q <= 1'b1;
      else if (!pulse_output_enable_q)
         wave_q <= 1'b1;                                                       // start high
      else if (high_width_setting_q >= cycle_setting_q && cycle_setting_q != 6'h00)
         wave_q <= 1'b1;
      else if (hit)
      begin
         if (cnt_q + 6'h01 == high_width_setting_q)
            wave_q <= (cycle_setting_q == 6'h00);
         else if (cnt_q + 6'h01 == cycle_setting_q)
            wave_q <= 1'b1;
      end
   // ----------------------------------------------------------------
   // pin multiplexer
   // ----------------------------------------------------------------
   // route waveform or port level to the pin
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_pulse_output_pin      <= 1'b0;
         o_pulse_output_function <= 1'b0;
      end
      else
      begin
         o_pulse_output_pin      <= pulse_output_enable_q ? wave_q : i_port_data;
         o_pulse_output_function <= pulse_output_enable_q;
      end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_clear_when_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !pulse_output_enable_q |=> cnt_q == SBPG_CNT_ZERO)
      else $error("counter not cleared while disabled");
   a_pin_port_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !pulse_output_enable_q |=> o_pulse_output_pin == $past(i_port_data))
      else $error("pin not given to port");
   a_wide_holds_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && cycle_setting_q != 6'h00 && high_width_setting_q >= cycle_setting_q
      |=> wave_q)
      else $error("wide setting not high");
   a_count_only_hit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && !hit && $stable(pulse_output_enable_q) |=> $stable(cnt_q))
      else $error("counter moved without strobe");
   a_wrap_at_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && hit && cnt_q + 6'h01 == cycle_setting_q ##1 pulse_output_enable_q
      |-> cnt_q == SBPG_CNT_ZERO)
      else $error("counter did not wrap at cycle");
   a_low_after_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && hit && cycle_setting_q != 6'h00 && high_width_setting_q < cycle_setting_q
      && cnt_q + 6'h01 == high_width_setting_q |=> !wave_q)
      else $error("no low after width match");
   a_cycle0_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && hit && cycle_setting_q == 6'h00
      && cnt_q + 6'h01 == high_width_setting_q |=> wave_q)
      else $error("cycle zero not high after match");
   a_pin_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q |=> o_pulse_output_pin == $past(wave_q))
      else $error("pin does not follow waveform");
   a_bus_one_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("answer later than one wait");
   // answer lasts exactly one cycle
   a_wait_one_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   // read data of the width register stands in the answer cycle
   a_read_width_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_avs_read && !o_avs_waitrequest && i_avs_address == SBPG_OFS_CLK_WIDTH
      |-> o_avs_readdata[7:0] == {count_clock_select_q, high_width_setting_q})
      else $error("width register read data wrong");
   // read data of the cycle register stands in the answer cycle
   a_read_cycle_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_avs_read && !o_avs_waitrequest && i_avs_address == SBPG_OFS_EN_CYCLE
      |-> o_avs_readdata[7:0] == {pulse_output_enable_q, 1'b0, cycle_setting_q})
      else $error("cycle register read data wrong");
   // width write lands on the answer edge
   a_write_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_avs_write && !o_avs_waitrequest && lane0 && i_avs_address == SBPG_OFS_CLK_WIDTH
      |=> high_width_setting_q == $past(i_avs_writedata[SBPG_VAL_MSB:0])
      && count_clock_select_q == $past(i_avs_writedata[SBPG_SEL_MSB:SBPG_SEL_LSB]))
      else $error("width write lost");
   // cycle write lands on the answer edge
   a_write_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_avs_write && !o_avs_waitrequest && lane0 && i_avs_address == SBPG_OFS_EN_CYCLE
      |=> cycle_setting_q == $past(i_avs_writedata[SBPG_VAL_MSB:0])
      && pulse_output_enable_q == $past(i_avs_writedata[SBPG_EN_BIT]))
      else $error("cycle write lost");
   // writes without the low byte lane leave width, cycle and enable unchanged
   a_lane_ignored: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_avs_write && !lane0
      |=> $stable(high_width_setting_q) && $stable(cycle_setting_q) && $stable(pulse_output_enable_q))
      else $error("write without low lane took effect");
   // counter steps by one on the selected strobe
   a_count_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && hit && cnt_q + 6'h01 != cycle_setting_q
      |=> cnt_q == $past(cnt_q) + 6'h01)
      else $error("counter did not step");
   // waveform high again at each wrap
   a_high_at_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q && hit && cycle_setting_q != 6'h00 && cnt_q + 6'h01 == cycle_setting_q
      |=> wave_q)
      else $error("waveform not high at wrap");
   // disabled waveform rests high, ready for a new period
   a_wave_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !pulse_output_enable_q |=> wave_q)
      else $error("waveform not rested high");
   // pin function flag follows the enable
   a_func_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pulse_output_enable_q |=> o_pulse_output_function)
      else $error("pin not given to waveform");
   a_func_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !pulse_output_enable_q |=> !o_pulse_output_function)
      else $error("pin kept by waveform");
endmodule : sbpg_top
`default_nettype wire

// File: test/sbpg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sbpg_top_tb;
   import sbpg_pkg::*;
   localparam int INST = 1;                            // one clock per instruction cycle
   localparam int LIM  = 9000;                         // bound on the total of all waits in measure
   logic        i_ref_clk, i_rst_n, rd, wr, port, wreq, pin, func;
   logic [3:0]  adr, be;
   logic [31:0] wd, rdat, q;
   logic [15:0] lfsr_q;                                // random source
   logic [1:0]  sel;
   logic [5:0]  cyc, wid;
   int          n_errors, cmp_count, hi, per, i;
   sbpg_top #(.INST_CYC(INST)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_port_data(port), .o_pulse_output_pin(pin), .o_pulse_output_function(func));
   // free running clock
   initial
   begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   // expected length in clocks of a count of count clocks
   function automatic int exp_len(input logic [1:0] s, input int cnt);
      int d[4];
      d = '{SBPG_DIV_0, SBPG_DIV_1, SBPG_DIV_2, SBPG_DIV_3};
      return cnt * d[s] * INST;
   endfunction : exp_len
   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t word %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t level %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   task automatic chk_len(input int g, input int e);
      cmp_count++;
      if (g != e)
      begin
         n_errors++;
         $display("ERROR %0t length %0d expected %0d", $time, g, e);
      end
   endtask : chk_len
   // one avalon transfer, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      int g;
      g = 0;
      @(posedge i_ref_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      do
      begin
         @(posedge i_ref_clk);
         g++;
      end
      while (wreq !== 1'b0 && g < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wreq !== 1'b0)
      begin
         n_errors++;
         $display("ERROR %0t bus hang", $time);
         conclude();
      end
   endtask : bus
   // high time and period of one full waveform cycle
   task automatic measure();
      int g;
      g = 0;
      hi = 0;
      while (pin !== 1'b0 && g < LIM)
      begin
         @(negedge i_ref_clk);
         g++;
      end
      while (pin !== 1'b1 && g < LIM)
      begin
         @(negedge i_ref_clk);
         g++;
      end
      while (pin === 1'b1 && g < LIM)
      begin
         @(negedge i_ref_clk);
         g++;
         hi++;
      end
      per = hi;
      while (pin === 1'b0 && g < LIM)
      begin
         @(negedge i_ref_clk);
         g++;
         per++;
      end
      if (g >= LIM)
      begin
         n_errors++;
         $display("ERROR %0t no waveform", $time);
         conclude();
      end
   endtask : measure
   task automatic hold_high(input int n);
      repeat (4) @(negedge i_ref_clk);
      repeat (n)
      begin
         @(negedge i_ref_clk);
         chk_bit(pin, 1'b1);
      end
   endtask : hold_high
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      i_rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      be = 4'h0;
      port = 1'b0;
      lfsr_q = 16'h8218;
      n_errors = 0;
      cmp_count = 0;
      repeat (20) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      bus(1'b0, SBPG_OFS_CLK_WIDTH, 32'h0, 4'hF);
      chk_word(q, 32'h0);
      bus(1'b0, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
      chk_word(q, 32'h0);
      bus(1'b0, 4'hC, 32'h0, 4'hF);
      chk_word(q, 32'h0);
      bus(1'b1, SBPG_OFS_CLK_WIDTH, 32'hFF, 4'hE);
      bus(1'b0, SBPG_OFS_CLK_WIDTH, 32'h0, 4'hF);
      chk_word(q, 32'h0);
      // disabled: pin follows the port level
      for (i = 0; i < 4; i++)
      begin
         lfsr_q = lfsr_next(lfsr_q);
         @(posedge i_ref_clk);
         port <= lfsr_q[0];
         repeat (3) @(negedge i_ref_clk);
         chk_bit(pin, port);
         chk_bit(func, 1'b0);
      end
      // one waveform per count clock, corners at both ends
      for (i = 0; i < 4; i++)
      begin
         lfsr_q = lfsr_next(lfsr_q);
         sel = 2'(i);
         cyc = (i == 0) ? 6'h02 : (i == 3) ? 6'h3F : 6'h02 + 6'(lfsr_q % 16'h003E);
         wid = (i == 0) ? 6'h01 : (i == 3) ? 6'h3E : 6'h01 + 6'(lfsr_q[15:6] % 10'(cyc - 6'h01));
         bus(1'b1, SBPG_OFS_CLK_WIDTH, {24'h0, sel, wid}, 4'hF);
         bus(1'b1, SBPG_OFS_EN_CYCLE, {24'h0, 2'h3, cyc}, 4'hF);
         bus(1'b0, SBPG_OFS_CLK_WIDTH, 32'h0, 4'hF);
         chk_word(q, {24'h0, sel, wid});
         bus(1'b0, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
         chk_word(q, {24'h0, 2'h2, cyc});
         chk_bit(func, 1'b1);
         measure();
         chk_len(hi, exp_len(sel, int'(wid)));
         chk_len(per, exp_len(sel, int'(cyc)));
         bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
         bus(1'b0, SBPG_OFS_STATUS, 32'h0, 4'hF);
         chk_word(q & 32'h3F, 32'h0);
      end
      // width at or above cycle holds the pin high
      for (i = 0; i < 2; i++)
      begin
         bus(1'b1, SBPG_OFS_CLK_WIDTH, 32'h5 + 32'(i), 4'hF);
         bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h85, 4'hF);
         hold_high(40);
         bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
      end
      // cycle zero: high for good after the width match
      bus(1'b1, SBPG_OFS_CLK_WIDTH, 32'h3, 4'hF);
      bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h80, 4'hF);
      repeat (10) @(negedge i_ref_clk);
      hold_high(80);
      bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
      repeat (3) @(negedge i_ref_clk);
      chk_bit(pin, port);
      // reset in mid-run while enabled: everything back to rest
      bus(1'b1, SBPG_OFS_EN_CYCLE, 32'h85, 4'hF);
      repeat (4) @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(negedge i_ref_clk);
      chk_bit(pin, 1'b0);
      chk_bit(func, 1'b0);
      chk_bit(wreq, 1'b1);
      chk_word(rdat, 32'h0);
      @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      bus(1'b0, SBPG_OFS_EN_CYCLE, 32'h0, 4'hF);
      chk_word(q, 32'h0);
      conclude();
   end
endmodule : sbpg_top_tb
`default_nettype wire
